// ### include/dtirc_pkg.sv
// Package: register map, field layout and reset values of the timer interrupt and run control block
package dtirc_pkg;
  // Channel and source counts, priority field width
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned NUM_SRC = 4;
  localparam int unsigned PRIO_W = 2;
  // Register byte offsets on the bus (low 16 address bits)
  localparam logic [15:0] PRIO_OFFSET = 16'hFF20;
  localparam logic [15:0] IRQ_EN_OFFSET = 16'hFF24;
  localparam logic [15:0] FLAG_OFFSET = 16'hFF28;
  localparam logic [15:0] RUN_OFFSET = 16'hFF2C;
  // Source order: ch0 underflow, ch0 compare, ch1 underflow, ch1 compare, at data bits 3..6
  localparam int unsigned SRC_LSB = 3;
  // Run register fields
  localparam int unsigned RUN_CH0_BIT = 0;
  localparam int unsigned RUN_CH1_BIT = 1;
  localparam int unsigned RUN_CASCADE_BIT = 2;
  // Reset values
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic [1:0] RUN_RESET = 2'h0;
  localparam logic CASCADE_RESET = 1'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Interrupt priority levels
  typedef enum logic [1:0] {
    DTIRC_LVL_NONE = 2'b00,
    DTIRC_LVL_1 = 2'b01,
    DTIRC_LVL_2 = 2'b10,
    DTIRC_LVL_3 = 2'b11
  } dtirc_level_e;
  // Write channel states
  typedef enum logic {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } dtirc_wr_e;
endpackage : dtirc_pkg

// ### include/dtirc_core_if.sv
// Interface: signals between the register front end and the interrupt and run units
interface dtirc_core_if;
  logic cascade; // 16-bit cascaded mode
  logic [3:0] irqEnable; // Enable bits per source
  logic [3:0] prioField; // Two priority bits per channel
  logic [1:0] cpuMask; // CPU current mask level
  logic [3:0] flagClear; // Write-one clear pulse per flag
  logic [3:0] eventIn; // Event pulses from the counter core
  logic [3:0] flagState; // Factor flags
  logic [3:0] irqReqVec; // Request per source
  logic irqReq; // Any request
  logic [1:0] irqLevel; // Highest requesting level
  logic [1:0] runReq; // Software run requests
  logic [1:0] runState; // Applied run state
  logic [1:0] countTick; // Count pulses to the core
  logic [1:0] chClk; // Selected input clock levels
  logic sleep; // Processor in sleep
  modport ctl (output cascade, irqEnable, prioField, cpuMask, flagClear, eventIn, runReq, chClk, sleep,
               input flagState, irqReqVec, irqReq, irqLevel, runState, countTick);
  modport irq (input cascade, irqEnable, prioField, cpuMask, flagClear, eventIn,
               output flagState, irqReqVec, irqReq, irqLevel);
  modport run (input cascade, runReq, chClk, sleep, output runState, countTick);
endinterface : dtirc_core_if

// ### core/dtirc_irq_unit.sv
// Factor flags and prioritised interrupt request generation
module dtirc_irq_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  dtirc_core_if.irq core
);
  logic [3:0] srcLive; // Sources alive in the current mode
  logic [3:0] flag_q; // Sticky factor flags
  logic [3:0] req_d; // Request per source, next value
  logic [3:0] req_q;
  logic [1:0] level_d; // Highest level among requests
  logic [1:0] level_q;
  logic any_q;

  // Channel-0 sources are dead in cascaded mode
  always_comb begin
    srcLive = 4'hF;
    if (core.cascade) begin
      srcLive[1:0] = 2'h0;
    end
  end

  // Flags set regardless of enable or priority; a set in the clear cycle survives
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= dtirc_pkg::FLAG_RESET;
    end else begin
      flag_q <= (flag_q & ~core.flagClear) | (core.eventIn & srcLive);
    end
  end

  // Request and level per source; a level must beat the CPU mask strictly
  always_comb begin
    logic [1:0] lvl;
    lvl = 2'h0;
    level_d = dtirc_pkg::DTIRC_LVL_NONE;
    for (int i = 0; i < 4; i++) begin
      lvl = core.prioField[2*(i/2) +: 2];
      req_d[i] = flag_q[i] & core.irqEnable[i] & srcLive[i] & (lvl > core.cpuMask);
      if (req_d[i] && (lvl > level_d)) begin
        level_d = lvl;
      end
    end
  end

  // Registered request outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 4'h0;
      level_q <= dtirc_pkg::DTIRC_LVL_NONE;
      any_q <= 1'b0;
    end else begin
      req_q <= req_d;
      level_q <= level_d;
      any_q <= |req_d;
    end
  end

  assign core.flagState = flag_q;
  assign core.irqReqVec = req_q;
  assign core.irqLevel = level_q;
  assign core.irqReq = any_q;
endmodule : dtirc_irq_unit

// ### core/dtirc_run_unit.sv
// Run/stop application on the falling edge of each channel's input clock (channel 0's for both in cascade), with sleep hold-off
module dtirc_run_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  dtirc_core_if.run core
);
  logic [1:0] clkPrev_q; // Previous input clock level
  logic [1:0] fall; // Falling edge seen this cycle
  logic [1:0] runAct_q; // Applied run state
  logic [1:0] tick_q; // Count pulse

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic reqEff; // Request that governs this channel
    logic fallEff; // Edge that applies it
    // In cascade channel 1 follows channel 0 request and clock
    assign reqEff = core.cascade ? core.runReq[0] : core.runReq[ch];
    assign fallEff = core.cascade ? fall[0] : fall[ch];
    assign fall[ch] = clkPrev_q[ch] & ~core.chClk[ch];

    // Edge detector on the selected input clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        clkPrev_q[ch] <= 1'b0;
      end else begin
        clkPrev_q[ch] <= core.chClk[ch];
      end
    end

    // New run state takes effect only at a falling edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        runAct_q[ch] <= 1'b0;
      end else if (fallEff) begin
        runAct_q[ch] <= reqEff;
      end
    end

    // Tick uses the old run state, so a stop still yields one last count
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        tick_q[ch] <= 1'b0;
      end else begin
        tick_q[ch] <= fallEff & runAct_q[ch] & ~core.sleep;
      end
    end
  end

  assign core.runState = runAct_q;
  assign core.countTick = tick_q;
endmodule : dtirc_run_unit

// ### core/dtirc_top.sv
// Top: AXI4-Lite register front end of the dual timer interrupt and run control
// Function
// - Per-channel readable underflow interrupt enable bit
// - Per-channel readable compare interrupt enable bit
// - Cascade mode ignores channel-0 enable bits
// - Reset clears all interrupt enable bits
// - Underflow sets the channel underflow flag
// - Compare match sets the channel compare flag
// - Flags set regardless of enable, priority
// - Request when flag, enable, level above mask
// - Writing one clears flag, zero ignored
// - Cascade: no channel-0 flags or requests
// - Cascade: 16-bit match sets channel-1 compare
// - Reset clears all factor flags
// - Run change applies at input clock fall
// - Stopping allows one more count
// - Run bit reads one until stopped
// - Sleep suspends counting, resumes after wake
// - Two-bit priority per channel, resets zero
// - Cascade: channel-0 run drives both, ch1 zero
module dtirc_top #(
  parameter int unsigned ADDR_W = 16 // Decoded address width
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] chInClk,
  input wire logic [1:0] underflowEvt,
  input wire logic [1:0] compareEvt,
  input wire logic [1:0] cpuMaskLevel,
  input wire logic sleepInstrActive,
  output logic irqRequest,
  output logic [1:0] irqLevel,
  output logic [3:0] irqSourceReq,
  output logic [1:0] runState,
  output logic [1:0] countTick
);

  // Refuse an address too narrow to reach the register page
  if (ADDR_W < 16) begin : g_addr_check
    $error("dtirc_top: ADDR_W must be at least 16");
  end

  dtirc_core_if core (); // Shared signals to the two units

  // Software registers
  logic [3:0] irqEn_q; // Enable bits, bit order of sources
  logic [3:0] prio_q; // [1:0] channel 0, [3:2] channel 1
  logic [1:0] runReq_q; // Software run requests
  logic cascade_q; // 16-bit cascaded mode

  // Write channel holding registers
  dtirc_pkg::dtirc_wr_e wrState_q;
  dtirc_pkg::dtirc_wr_e wrState_d;
  logic awHeld_q;
  logic awHeld_d;
  logic wHeld_q;
  logic wHeld_d;
  logic [15:0] awAddr_q; // Captured word address
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awReady_q;
  logic wReady_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic wrFire; // Both halves held, perform the write
  logic wrHit; // Write address is mapped
  logic lane0; // Low byte lane written

  // Read channel registers
  logic arReady_q;
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic arFire;
  logic [15:0] arWord; // Read word address
  logic [31:0] rdMux;
  logic rdHit;

  // Address decode helpers
  logic [15:0] awWord;
  assign awWord = {s_axi_awaddr[15:2], 2'b00};
  assign arWord = {s_axi_araddr[15:2], 2'b00};

  // Write path next state: address and data may arrive in either order
  always_comb begin
    wrState_d = wrState_q;
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    case (wrState_q)
      dtirc_pkg::WR_COLLECT: begin
        if (s_axi_awvalid && awReady_q) begin
          awHeld_d = 1'b1;
        end
        if (s_axi_wvalid && wReady_q) begin
          wHeld_d = 1'b1;
        end
        if (awHeld_q && wHeld_q) begin
          // Write is performed now; both holds drop
          wrState_d = dtirc_pkg::WR_RESP;
          awHeld_d = 1'b0;
          wHeld_d = 1'b0;
        end
      end
      dtirc_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          wrState_d = dtirc_pkg::WR_COLLECT;
        end
      end
      default: begin
        wrState_d = dtirc_pkg::WR_COLLECT;
      end
    endcase
  end

  assign wrFire = (wrState_q == dtirc_pkg::WR_COLLECT) && awHeld_q && wHeld_q;
  assign lane0 = wStrb_q[0];
  assign wrHit = (awAddr_q == dtirc_pkg::PRIO_OFFSET) || (awAddr_q == dtirc_pkg::IRQ_EN_OFFSET) ||
                 (awAddr_q == dtirc_pkg::FLAG_OFFSET) || (awAddr_q == dtirc_pkg::RUN_OFFSET);

  // Write channel flops; readies come straight from flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrState_q <= dtirc_pkg::WR_COLLECT;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awReady_q <= 1'b0;
      wReady_q <= 1'b0;
    end else begin
      wrState_q <= wrState_d;
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      // Ready only while collecting and that half is still free
      awReady_q <= (wrState_d == dtirc_pkg::WR_COLLECT) && !awHeld_d;
      wReady_q <= (wrState_d == dtirc_pkg::WR_COLLECT) && !wHeld_d;
    end
  end

  // Captured write address and data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awAddr_q <= 16'h0000;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awReady_q) begin
        awAddr_q <= awWord;
      end
      if (s_axi_wvalid && wReady_q) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response; an unmapped address answers SLVERR and changes nothing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bValid_q <= 1'b0;
      bResp_q <= dtirc_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bValid_q <= 1'b1;
      bResp_q <= wrHit ? dtirc_pkg::RESP_OKAY : dtirc_pkg::RESP_SLVERR;
    end else if (bValid_q && s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Enable and priority registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEn_q <= dtirc_pkg::IRQ_EN_RESET;
      prio_q <= dtirc_pkg::PRIO_RESET;
    end else if (wrFire && lane0) begin
      if (awAddr_q == dtirc_pkg::IRQ_EN_OFFSET) begin
        irqEn_q <= wData_q[dtirc_pkg::SRC_LSB +: 4];
      end
      if (awAddr_q == dtirc_pkg::PRIO_OFFSET) begin
        prio_q <= wData_q[3:0];
      end
    end
  end

  // Run requests and mode; channel 1 request is forced to 0 in cascade
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      runReq_q <= dtirc_pkg::RUN_RESET;
      cascade_q <= dtirc_pkg::CASCADE_RESET;
    end else if (wrFire && lane0 && (awAddr_q == dtirc_pkg::RUN_OFFSET)) begin
      runReq_q[0] <= wData_q[dtirc_pkg::RUN_CH0_BIT];
      runReq_q[1] <= wData_q[dtirc_pkg::RUN_CH1_BIT] & ~wData_q[dtirc_pkg::RUN_CASCADE_BIT];
      cascade_q <= wData_q[dtirc_pkg::RUN_CASCADE_BIT];
    end
  end

  // Write-one clear pulse to the flags, same cycle as the write
  always_comb begin
    core.flagClear = 4'h0;
    if (wrFire && lane0 && (awAddr_q == dtirc_pkg::FLAG_OFFSET)) begin
      core.flagClear = wData_q[dtirc_pkg::SRC_LSB +: 4];
    end
  end

  // Interface drive toward the units
  assign core.cascade = cascade_q;
  assign core.irqEnable = irqEn_q;
  assign core.prioField = prio_q;
  assign core.cpuMask = cpuMaskLevel;
  // Channel 1 events carry the 16-bit counter's underflow and full match in cascade
  assign core.eventIn = {compareEvt[1], underflowEvt[1], compareEvt[0], underflowEvt[0]};
  assign core.runReq = runReq_q;
  assign core.chClk = chInClk;
  assign core.sleep = sleepInstrActive;

  // Read data mux; run bits read 1 until the counter has really stopped, except channel 1 which reads 0 in cascade
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case (arWord)
      dtirc_pkg::PRIO_OFFSET: begin
        rdMux[3:0] = prio_q;
      end
      dtirc_pkg::IRQ_EN_OFFSET: begin
        rdMux[dtirc_pkg::SRC_LSB +: 4] = irqEn_q;
      end
      dtirc_pkg::FLAG_OFFSET: begin
        rdMux[dtirc_pkg::SRC_LSB +: 4] = core.flagState;
      end
      dtirc_pkg::RUN_OFFSET: begin
        rdMux[dtirc_pkg::RUN_CH0_BIT] = runReq_q[0] | core.runState[0];
        rdMux[dtirc_pkg::RUN_CH1_BIT] = ~cascade_q & (runReq_q[1] | core.runState[1]);
        rdMux[dtirc_pkg::RUN_CASCADE_BIT] = cascade_q;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  assign arFire = s_axi_arvalid && arReady_q;

  // Read channel: one outstanding read, answer one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= dtirc_pkg::RESP_OKAY;
    end else begin
      if (arFire) begin
        rValid_q <= 1'b1;
        rData_q <= rdMux;
        rResp_q <= rdHit ? dtirc_pkg::RESP_OKAY : dtirc_pkg::RESP_SLVERR;
      end else if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
      end
      // Address is refused while a read answer is pending
      arReady_q <= !(arFire || (rValid_q && !s_axi_rready));
    end
  end

  // Interrupt flags and request generation
  dtirc_irq_unit u_irq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .core(core.irq)
  );

  // Run/stop timing and sleep hold-off
  dtirc_run_unit u_run (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .core(core.run)
  );

  // Outputs, each from a flop here or in a unit
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign irqRequest = core.irqReq;
  assign irqLevel = core.irqLevel;
  assign irqSourceReq = core.irqReqVec;
  assign runState = core.runState;
  assign countTick = core.countTick;
endmodule : dtirc_top

// ### verification/dtirc_core_model.sv
// Counter core stand-in: gated input clock source and count-step tally
module dtirc_core_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [1:0] countTick,
  output logic [1:0] chInClk,
  output logic [15:0] tickCount
);
  logic [2:0] divQ; // Divider phase: high half, then low half
  // Clock stands high while gated, so no stray fall reaches the block
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divQ <= 3'h0;
    end else if (clkEn) begin
      divQ <= divQ + 3'h1;
    end else begin
      divQ <= 3'h0;
    end
  end
  // One source for both channels, as the cascaded pair also shares it
  assign chInClk = {2{~divQ[2]}};
  // Steps on both channels; a stray channel-1 step spoils the tallies
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCount <= 16'h0;
    end else begin
      tickCount <= tickCount + 16'(countTick[0]) + 16'(countTick[1]);
    end
  end
endmodule : dtirc_core_model

// ### verification/dtirc_top_props.sv
// Checker: bus timing, request and run/tick relations at the top ports
module dtirc_top_props #(
  parameter int unsigned ADDR_W = 16 // Decoded address width
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] chInClk,
  input wire logic [1:0] underflowEvt,
  input wire logic [1:0] compareEvt,
  input wire logic [1:0] cpuMaskLevel,
  input wire logic sleepInstrActive,
  input wire logic irqRequest,
  input wire logic [1:0] irqLevel,
  input wire logic [3:0] irqSourceReq,
  input wire logic [1:0] runState,
  input wire logic [1:0] countTick
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Address and data of a write taken at one edge
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_a: assert property (wrTaken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after take");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  rd_resp_a: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after take");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not retired");
  req_any_a: assert property (irqRequest == (|irqSourceReq))
    else $error("request line disagrees with sources");
  idle_level_a: assert property (!irqRequest |-> irqLevel == 2'h0)
    else $error("level shown without request");
  mask_above_a: assert property (irqRequest |-> irqLevel > $past(cpuMaskLevel))
    else $error("request not above mask level");
  tick_low_a: assert property (countTick[0] |-> !chInClk[0] && !$past(chInClk[0]))
    else $error("count step outside input clock low phase");
  tick_run_a: assert property (countTick[0] |-> $past(runState[0]))
    else $error("count step without running state");
  sleep_quiet_a: assert property (sleepInstrActive && $past(sleepInstrActive) |-> countTick == 2'h0)
    else $error("count step during sleep");
  reset_quiet_a: assert property ($rose(rst_n) |-> irqSourceReq == 4'h0 && runState == 2'h0)
    else $error("activity right after reset");
endmodule : dtirc_top_props

bind dtirc_top dtirc_top_props #(.ADDR_W(ADDR_W)) u_props (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .chInClk, .underflowEvt, .compareEvt, .cpuMaskLevel, .sleepInstrActive, .irqRequest,
  .irqLevel, .irqSourceReq, .runState, .countTick);

// ### verification/testbench.sv
// Testbench: registers, flags, requests, cascade mode and run/stop of the timer block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst_n = 1'h0, clkEn = 1'h0, sleepInstrActive = 1'h0; // Clock, reset, stimulus
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, tickCount; // Addresses, step tally
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, irqSourceReq;
  logic [1:0] underflowEvt = 2'h0, compareEvt = 2'h0, cpuMaskLevel = 2'h0, s_axi_bresp, s_axi_rresp;
  logic [1:0] chInClk, irqLevel, runState, countTick;
  logic irqRequest;
  int num_errors = 0, total_checks = 0, cycles = 0; // Verdict counters and hang guard
  dtirc_top u_dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chInClk, .underflowEvt,
    .compareEvt, .cpuMaskLevel, .sleepInstrActive, .irqRequest, .irqLevel, .irqSourceReq, .runState, .countTick);
  dtirc_core_model u_core (.ref_clk, .rst_n, .clkEn, .countTick, .chInClk, .tickCount);
  // 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // The whole run needs well under a thousand cycles; far more means a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bit awPend = 1'b1;
    bit wPend = 1'b1;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (awPend || wPend) begin
      @(posedge ref_clk);
      if (awPend && s_axi_awready) begin
        awPend = 1'b0;
        s_axi_awvalid <= 1'h0;
      end
      if (wPend && s_axi_wready) begin
        wPend = 1'b0;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'h1);
    check("bresp", 32'(s_axi_bresp), 32'(dtirc_pkg::RESP_OKAY));
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rdr
  task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    check(n, d, e);
  endtask : rdc
  // One-cycle event pulses from the counter core
  task automatic pulse(input logic [1:0] u, input logic [1:0] c);
    @(posedge ref_clk);
    underflowEvt <= u;
    compareEvt <= c;
    @(posedge ref_clk);
    underflowEvt <= 2'h0;
    compareEvt <= 2'h0;
  endtask : pulse
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdc("priority", 16'hFF20, 32'h0);
    rdc("enables", 16'hFF24, 32'h0);
    rdc("flags", 16'hFF28, 32'h0);
    rdc("run", 16'hFF2C, 32'h0);
    rdr(16'hFF30, d, r);
    check("unmapped resp", 32'(r), 32'(dtirc_pkg::RESP_SLVERR));
    $display("test_reset done");
  endtask : test_reset
  task automatic test_flags();
    wr(16'hFF24, 32'h0);
    pulse(2'h3, 2'h3);
    rdc("flags set", 16'hFF28, 32'h78);
    check("blocked", 32'(irqSourceReq), 32'h0);
    wr(16'hFF28, 32'h0);
    rdc("zero write", 16'hFF28, 32'h78);
    s_axi_wstrb <= 4'hE;
    wr(16'hFF28, 32'h08);
    s_axi_wstrb <= 4'hF;
    rdc("lane off", 16'hFF28, 32'h78);
    // Event lands in the very cycle the clear is applied
    fork
      wr(16'hFF28, 32'h08);
      begin
        idle(1);
        pulse(2'h1, 2'h0);
      end
    join
    rdc("set wins", 16'hFF28, 32'h78);
    wr(16'hFF28, 32'h08);
    rdc("one clear", 16'hFF28, 32'h70);
    $display("test_flags done");
  endtask : test_flags
  task automatic test_irq();
    wr(16'hFF20, 32'h06);
    wr(16'hFF24, 32'h78);
    cpuMaskLevel <= 2'h1;
    idle(3);
    check("src mask1", 32'(irqSourceReq), 32'h2);
    check("lvl mask1", 32'(irqLevel), 32'h2);
    cpuMaskLevel <= 2'h2;
    idle(3);
    check("req mask2", 32'(irqRequest), 32'h0);
    cpuMaskLevel <= 2'h0;
    idle(3);
    check("src mask0", 32'(irqSourceReq), 32'hE);
    wr(16'hFF24, 32'h68);
    idle(3);
    check("src en", 32'(irqSourceReq), 32'hC);
    check("lvl en", 32'(irqLevel), 32'h1);
    wr(16'hFF28, 32'h70);
    idle(3);
    check("req cleared", 32'(irqRequest), 32'h0);
    $display("test_irq done");
  endtask : test_irq
  task automatic test_cascade();
    wr(16'hFF2C, 32'h06);
    rdc("mode", 16'hFF2C, 32'h04);
    wr(16'hFF20, 32'h0F);
    wr(16'hFF24, 32'h18);
    pulse(2'h1, 2'h1);
    rdc("ch0 flags", 16'hFF28, 32'h0);
    check("ch0 req", 32'(irqRequest), 32'h0);
    wr(16'hFF24, 32'h58);
    pulse(2'h0, 2'h2);
    idle(3);
    rdc("wide match", 16'hFF28, 32'h40);
    check("wide src", 32'(irqSourceReq), 32'h8);
    check("wide lvl", 32'(irqLevel), 32'h3);
    pulse(2'h2, 2'h0);
    rdc("wide under", 16'hFF28, 32'h60);
    wr(16'hFF28, 32'h60);
    wr(16'hFF24, 32'h0);
    wr(16'hFF2C, 32'h04);
    rdc("wide stop", 16'hFF2C, 32'h04);
    wr(16'hFF2C, 32'h0);
    $display("test_cascade done");
  endtask : test_cascade
  task automatic test_run();
    logic [15:0] t0;
    wr(16'hFF2C, 32'h01);
    idle(20);
    check("held start", 32'(runState), 32'h0);
    clkEn <= 1'h1;
    for (int i = 0; i < 40 && runState[0] !== 1'h1; i++) @(posedge ref_clk);
    check("started", 32'(runState), 32'h1);
    t0 = tickCount;
    idle(64);
    check("steps", 32'((tickCount - t0) inside {[16'h7:16'h8]}), 32'h1);
    sleepInstrActive <= 1'h1;
    idle(2);
    t0 = tickCount;
    idle(40);
    check("sleep", 32'(tickCount), 32'(t0));
    sleepInstrActive <= 1'h0;
    idle(40);
    check("wake", 32'(tickCount != t0), 32'h1);
    clkEn <= 1'h0;
    idle(8);
    t0 = tickCount;
    wr(16'hFF2C, 32'h0);
    rdc("stopping", 16'hFF2C, 32'h01);
    check("still run", 32'(runState), 32'h1);
    clkEn <= 1'h1;
    for (int i = 0; i < 40 && runState[0] !== 1'h0; i++) @(posedge ref_clk);
    idle(4);
    clkEn <= 1'h0;
    check("last step", 32'(tickCount - t0), 32'h1);
    rdc("stopped", 16'hFF2C, 32'h0);
    sleepInstrActive <= 1'h1;
    clkEn <= 1'h1;
    idle(24);
    check("sleep stop", 32'(tickCount - t0), 32'h1);
    $display("test_run done");
  endtask : test_run
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    idle(2);
    test_reset();
    test_flags();
    test_irq();
    test_cascade();
    test_run();
    give_verdict();
  end
endmodule : testbench
